// >>> verilog/isc_map.svh
// Timing constants and widths of the serial infrared pulse codec.
`ifndef ISC_MAP_SVH
`define ISC_MAP_SVH

`define ISC_CNT_W       4
`define ISC_CNT_ZERO    4'h0
`define ISC_CNT_ONE     4'h1
`define ISC_TX_RISE     4'h7
`define ISC_TX_FALL     4'hA
`define ISC_RX_LOW_LAST 4'hF
`define ISC_SAMPLE_CNT  4'h8
`define ISC_BIT_LAST    4'hF
`define ISC_SYNC_DEPTH  3
`define ISC_DATA_BITS   8
`define ISC_IDX_W       4
`define ISC_IDX_ZERO    4'h0

`endif

// >>> verilog/isc_pkg.sv
// Types shared by the codec end and the UART end.
package isc_pkg;

  typedef enum logic [0:0] {
    ISC_ENC_IDLE,
    ISC_ENC_PULSE
  } isc_enc_state_t;

  typedef enum logic [0:0] {
    ISC_DEC_IDLE,
    ISC_DEC_LOW
  } isc_dec_state_t;

  typedef enum logic [1:0] {
    ISC_URX_IDLE,
    ISC_URX_START,
    ISC_URX_DATA,
    ISC_URX_STOP
  } isc_urx_state_t;

  typedef enum logic [0:0] {
    ISC_UTX_IDLE,
    ISC_UTX_SEND
  } isc_utx_state_t;

endpackage

// >>> verilog/isc_link_if.sv
// Serial lines between the UART end and the infrared codec end.
`timescale 1ns/1ps
interface isc_link_if;
  logic uart_txd;
  logic uart_rxd;

  modport codec (
    input  uart_txd,
    output uart_rxd
  );

  modport uart (
    output uart_txd,
    input  uart_rxd
  );
endinterface

// >>> verilog/isc_codec.sv
// Infrared pulse encoder and decoder facing the UART serial lines.
`timescale 1ns/1ps
`include "isc_map.svh"
module isc_codec
  import isc_pkg::*;
#(
  parameter int SYNC_DEPTH = `ISC_SYNC_DEPTH
) (
  input  wire logic  ref_clk_in,
  input  wire logic  rst_in,
  isc_link_if.codec  link,
  input  wire logic  ir_receive_in,
  output logic       ir_transmit_out
);

  typedef struct packed {
    isc_enc_state_t          enc_state;
    logic [`ISC_CNT_W-1:0]   enc_cnt;
    logic                    ir_tx;
    logic [SYNC_DEPTH-1:0]   rx_sync;
    logic                    rx_level;
    isc_dec_state_t          dec_state;
    logic [`ISC_CNT_W-1:0]   dec_cnt;
    logic                    uart_rx;
  } isc_codec_st_t;

  isc_codec_st_t st_q;
  isc_codec_st_t st_d;

  logic                  rx_new_level;
  logic                  rx_fall;
  logic [`ISC_CNT_W-1:0] enc_next;

  always_comb begin
    st_d         = st_q;
    rx_new_level = st_q.rx_level;
    rx_fall      = 1'b0;
    enc_next     = `ISC_CNT_ZERO;

    // Receive pin shifts through the synchroniser; the first stage feeds only the second.
    st_d.rx_sync = {st_q.rx_sync[SYNC_DEPTH-2:0], ir_receive_in};

    // A change is accepted only once the last two stages agree.
    if (st_q.rx_sync[SYNC_DEPTH-1] == st_q.rx_sync[SYNC_DEPTH-2]) begin
      rx_new_level = st_q.rx_sync[SYNC_DEPTH-1];
    end
    st_d.rx_level = rx_new_level;
    // Only high-to-low counts, whatever the pulse polarity of the transceiver.
    rx_fall = st_q.rx_level & ~rx_new_level;

    // Encoder: bit period counter runs only while the transmit line is low.
    unique case (st_q.enc_state)
      ISC_ENC_IDLE: begin
        st_d.enc_cnt = `ISC_CNT_ZERO;
        st_d.ir_tx   = 1'b0;
        if (!link.uart_txd) begin
          st_d.enc_state = ISC_ENC_PULSE;
          st_d.enc_cnt   = `ISC_CNT_ONE;
        end
      end
      ISC_ENC_PULSE: begin
        if (link.uart_txd) begin
          st_d.enc_state = ISC_ENC_IDLE;
          st_d.enc_cnt   = `ISC_CNT_ZERO;
          st_d.ir_tx     = 1'b0;
        end else begin
          // The counter wraps every sixteen clocks, one pulse per zero bit.
          enc_next     = st_q.enc_cnt + `ISC_CNT_ONE;
          st_d.enc_cnt = enc_next;
          // High from the seventh to the tenth clock: three clocks wide.
          st_d.ir_tx   = (st_q.enc_cnt >= `ISC_TX_RISE) &&
                         (st_q.enc_cnt < `ISC_TX_FALL);
        end
      end
    endcase

    // Decoder: each accepted falling edge gives sixteen clocks of low.
    unique case (st_q.dec_state)
      ISC_DEC_IDLE: begin
        st_d.uart_rx = 1'b1;
        st_d.dec_cnt = `ISC_CNT_ZERO;
        if (rx_fall) begin
          st_d.dec_state = ISC_DEC_LOW;
          st_d.uart_rx   = 1'b0;
        end
      end
      ISC_DEC_LOW: begin
        if (rx_fall) begin
          // A fresh edge restarts the low period, so back-to-back zeros join.
          st_d.dec_cnt = `ISC_CNT_ZERO;
          st_d.uart_rx = 1'b0;
        end else if (st_q.dec_cnt == `ISC_RX_LOW_LAST) begin
          st_d.dec_state = ISC_DEC_IDLE;
          st_d.dec_cnt   = `ISC_CNT_ZERO;
          st_d.uart_rx   = 1'b1;
        end else begin
          st_d.dec_cnt = st_q.dec_cnt + `ISC_CNT_ONE;
        end
      end
    endcase

    if (rst_in) begin
      st_d.enc_state = ISC_ENC_IDLE;
      st_d.enc_cnt   = `ISC_CNT_ZERO;
      st_d.ir_tx     = 1'b0;
      // The synchroniser keeps sampling through reset, so the accepted level starts at the
      // pin's idle level whatever the pulse polarity, and no false fall follows release.
      st_d.rx_level  = st_q.rx_sync[SYNC_DEPTH-1];
      st_d.dec_state = ISC_DEC_IDLE;
      st_d.dec_cnt   = `ISC_CNT_ZERO;
      st_d.uart_rx   = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    st_q <= st_d;
  end

  assign ir_transmit_out = st_q.ir_tx;
  assign link.uart_rxd   = st_q.uart_rx;

endmodule

// >>> verilog/isc_uart_end.sv
// Minimal UART that feeds the codec and strobes its decoded data mid bit.
`timescale 1ns/1ps
`include "isc_map.svh"
module isc_uart_end
  import isc_pkg::*;
#(
  parameter int DATA_BITS = `ISC_DATA_BITS
) (
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_in,
  isc_link_if.uart                  link,
  input  wire logic [DATA_BITS-1:0] tx_data_in,
  input  wire logic                 tx_valid_in,
  output logic                      tx_ready_out,
  output logic      [DATA_BITS-1:0] rx_data_out,
  output logic                      rx_valid_out,
  output logic                      rx_frame_err_out
);

  typedef struct packed {
    isc_utx_state_t          tx_state;
    logic [DATA_BITS+1:0]    tx_shift;
    logic [`ISC_CNT_W-1:0]   tx_cnt;
    logic [`ISC_IDX_W-1:0]   tx_idx;
    logic                    txd;
    logic                    tx_ready;
    isc_urx_state_t          rx_state;
    logic                    rxd_prev;
    logic [`ISC_CNT_W-1:0]   rx_cnt;
    logic [`ISC_IDX_W-1:0]   rx_idx;
    logic [DATA_BITS-1:0]    rx_shift;
    logic [DATA_BITS-1:0]    rx_data;
    logic                    rx_valid;
    logic                    rx_err;
  } isc_uart_st_t;

  localparam logic [`ISC_IDX_W-1:0] TX_LAST = `ISC_IDX_W'(DATA_BITS + 1);
  localparam logic [`ISC_IDX_W-1:0] RX_LAST = `ISC_IDX_W'(DATA_BITS - 1);

  isc_uart_st_t st_q;
  isc_uart_st_t st_d;
  logic         strobe;

  always_comb begin
    st_d          = st_q;
    st_d.rx_valid = 1'b0;
    st_d.rx_err   = 1'b0;
    st_d.rxd_prev = link.uart_rxd;
    strobe        = (st_q.rx_cnt == `ISC_SAMPLE_CNT);

    // Transmitter: start zero, data LSB first, stop one, sixteen clocks each.
    unique case (st_q.tx_state)
      ISC_UTX_IDLE: begin
        st_d.txd      = 1'b1;
        st_d.tx_ready = 1'b1;
        if (tx_valid_in && st_q.tx_ready) begin
          st_d.tx_state = ISC_UTX_SEND;
          st_d.tx_shift = {1'b1, tx_data_in, 1'b0};
          st_d.tx_cnt   = `ISC_CNT_ZERO;
          st_d.tx_idx   = `ISC_IDX_ZERO;
          st_d.txd      = 1'b0;
          st_d.tx_ready = 1'b0;
        end
      end
      ISC_UTX_SEND: begin
        st_d.tx_cnt = st_q.tx_cnt + `ISC_CNT_ONE;
        if (st_q.tx_cnt == `ISC_BIT_LAST) begin
          if (st_q.tx_idx == TX_LAST) begin
            st_d.tx_state = ISC_UTX_IDLE;
            st_d.tx_ready = 1'b1;
            st_d.txd      = 1'b1;
          end else begin
            st_d.tx_idx   = st_q.tx_idx + `ISC_CNT_ONE;
            st_d.tx_shift = {1'b1, st_q.tx_shift[DATA_BITS+1:1]};
            st_d.txd      = st_q.tx_shift[1];
          end
        end
      end
    endcase

    // Receiver: the start edge aligns a sixteen-clock strobe at its eighth clock.
    if (st_q.rx_state != ISC_URX_IDLE) begin
      st_d.rx_cnt = st_q.rx_cnt + `ISC_CNT_ONE;
    end
    unique case (st_q.rx_state)
      ISC_URX_IDLE: begin
        if (st_q.rxd_prev && !link.uart_rxd) begin
          st_d.rx_state = ISC_URX_START;
          st_d.rx_cnt   = `ISC_CNT_ONE;
        end
      end
      ISC_URX_START: begin
        if (strobe) begin
          st_d.rx_idx   = `ISC_IDX_ZERO;
          st_d.rx_state = link.uart_rxd ? ISC_URX_IDLE : ISC_URX_DATA;
        end
      end
      ISC_URX_DATA: begin
        if (strobe) begin
          st_d.rx_shift = {link.uart_rxd, st_q.rx_shift[DATA_BITS-1:1]};
          st_d.rx_idx   = st_q.rx_idx + `ISC_CNT_ONE;
          if (st_q.rx_idx == RX_LAST) begin
            st_d.rx_state = ISC_URX_STOP;
          end
        end
      end
      ISC_URX_STOP: begin
        if (strobe) begin
          st_d.rx_state = ISC_URX_IDLE;
          st_d.rx_data  = st_q.rx_shift;
          st_d.rx_valid = link.uart_rxd;
          st_d.rx_err   = ~link.uart_rxd;
        end
      end
    endcase

    if (rst_in) begin
      st_d          = '0;
      st_d.tx_state = ISC_UTX_IDLE;
      st_d.rx_state = ISC_URX_IDLE;
      st_d.txd      = 1'b1;
      st_d.rxd_prev = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    st_q <= st_d;
  end

  assign link.uart_txd    = st_q.txd;
  assign tx_ready_out     = st_q.tx_ready;
  assign rx_data_out      = st_q.rx_data;
  assign rx_valid_out     = st_q.rx_valid;
  assign rx_frame_err_out = st_q.rx_err;

endmodule

// >>> dv/isc_link_monitor.sv
// Assertions on the serial and infrared lines of the codec.
`timescale 1ns/1ps
module isc_link_monitor (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic uart_txd,
  input wire logic uart_rxd,
  input wire logic ir_receive_in,
  input wire logic ir_transmit_out
);
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  a_tx_idle_low: assert property (uart_txd |=> !ir_transmit_out)
    else $error("ir pulse while txd high");
  a_pulse_shape: assert property ($fell(uart_txd) |-> ##1
    (!ir_transmit_out)[*7] ##1 ir_transmit_out[*3] ##1 !ir_transmit_out)
    else $error("pulse timing wrong");
  a_pulse_repeat: assert property ($fell(ir_transmit_out) ##0 (!uart_txd)[*8]
    ##1 (!uart_txd)[*5] |-> !ir_transmit_out ##1 ir_transmit_out)
    else $error("pulse not repeated");
  a_reset_state: assert property (disable iff (1'b0) rst_in
    |=> uart_rxd && uart_txd && !ir_transmit_out) else $error("reset state wrong");
  // The synchroniser and the edge compare put four edges between pin and output.
  a_rx_fall_low: assert property (ir_receive_in[*4] ##1 (!ir_receive_in)[*3]
    |-> ##2 !uart_rxd) else $error("rxd not low after fall");
  a_rx_low_span: assert property ($fell(uart_rxd) |-> (!uart_rxd)[*8]
    ##1 (!uart_rxd)[*8]) else $error("rxd low too short");
  a_rx_return_high: assert property ($fell(uart_rxd) ##1
    (!$fell(ir_receive_in))[*8] ##1 (!$fell(ir_receive_in))[*5]
    |=> (!uart_rxd)[*2] ##1 uart_rxd) else $error("rxd not back high");
  a_rx_fall_cause: assert property ($fell(uart_rxd)
    |-> $past(ir_receive_in, 5) && !$past(ir_receive_in, 4)) else $error("rxd fell alone");
endmodule

// >>> dv/irda_sir_pulse_codec_test.sv
// Bench joining the UART end and the codec, infrared side looped or driven.
`timescale 1ns/1ps
module irda_sir_pulse_codec_test;
  logic       ref_clk_in = 1'b0;
  logic       rst_in     = 1'b1;
  logic       loop       = 1'b1;
  logic       ir_drv     = 1'b1;
  logic [7:0] tx_data    = 8'h00;
  logic       tx_valid   = 1'b0;
  logic       ir_tx;
  logic       tx_ready;
  logic       rx_valid;
  logic       rx_err;
  logic [7:0] rx_data;
  logic [7:0] pat [4]    = '{8'h00, 8'hFF, 8'hA5, 8'h3C};
  int         fail_count = 0;
  int         compares   = 0;
  int         pulses     = 0;
  wire        ir_rx      = loop ? !ir_tx : ir_drv;
  isc_link_if link ();
  isc_codec u_isc_codec (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(link),
    .ir_receive_in(ir_rx), .ir_transmit_out(ir_tx));
  isc_uart_end u_isc_uart_end (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(link),
    .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_frame_err_out(rx_err));
  isc_link_monitor u_isc_link_monitor (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .uart_txd(link.uart_txd), .uart_rxd(link.uart_rxd), .ir_receive_in(ir_rx),
    .ir_transmit_out(ir_tx));
  initial begin
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ir_tx) pulses++;
  task automatic check(input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Ready is looked at on falling edges, so the rising edge that follows takes the byte.
  task automatic send_byte(input logic [7:0] d);
    int n;
    n = 0;
    @(negedge ref_clk_in);
    tx_data  = d;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1 && n < 400) begin
      @(negedge ref_clk_in);
      n++;
    end
    check(n < 400, 1'b1);
    @(negedge ref_clk_in);
    tx_valid = 1'b0;
  endtask
  task automatic wait_rx(input logic [7:0] d, input logic err);
    int n;
    n = 0;
    do @(negedge ref_clk_in); while (rx_valid !== 1'b1 && rx_err !== 1'b1 && ++n < 400);
    check(rx_valid, !err);
    check(rx_err, err);
    if (!err) check(rx_data, d);
  endtask
  // Late shifts odd-bit pulses one clock to provoke the one-clock glitch.
  task automatic ir_frame(input logic [9:0] f, input logic pos, late);
    for (int b = 0; b < 10; b++) begin
      for (int c = 0; c < 16; c++) begin
        @(negedge ref_clk_in);
        ir_drv = ~(pos ^ (!f[b] && c >= 7 + (late & b[0]) && c < 10 + (late & b[0])));
      end
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(20000 * 100);
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (10) @(negedge ref_clk_in);
    rst_in = 1'b0;
    check(ir_tx, 1'b0);
    check(link.uart_rxd, 1'b1);
    foreach (pat[i]) begin
      pulses = 0;
      fork
        send_byte(pat[i]);
        wait_rx(pat[i], 1'b0);
      join
      check(8'(pulses), 8'(9 - $countones(pat[i])));
    end
    loop = 1'b0;
    fork
      ir_frame({1'b1, 8'h00, 1'b0}, 1'b0, 1'b1);
      wait_rx(8'h00, 1'b0);
    join
    fork
      ir_frame({1'b0, 8'h5A, 1'b0}, 1'b0, 1'b0);
      wait_rx(8'h00, 1'b1);
    join
    repeat (20) @(negedge ref_clk_in);
    ir_drv = 1'b0;
    wait_rx(8'hFF, 1'b0);
    fork
      ir_frame({1'b1, 8'h96, 1'b0}, 1'b1, 1'b0);
      wait_rx(8'h96, 1'b0);
    join
    // A reset while the receive pin idles low must leave no false zero behind.
    rst_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    rst_in = 1'b0;
    repeat (10) @(negedge ref_clk_in);
    check(link.uart_rxd, 1'b1);
    loop = 1'b1;
    fork
      send_byte(8'h00);
    join_none
    repeat (25) @(negedge ref_clk_in);
    rst_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    check(ir_tx, 1'b0);
    check(link.uart_rxd, 1'b1);
    rst_in = 1'b0;
    repeat (30) @(negedge ref_clk_in);
    check(link.uart_txd, 1'b1);
    check(link.uart_rxd, 1'b1);
    print_verdict();
  end
endmodule
